/* File: common/saf_defines.vh */
// constants for the vector alignment fault checker
`ifndef SAF_DEFINES_VH
`define SAF_DEFINES_VH

// avalon register byte offsets
`define SAF_CTRL_OFFSET 8'h00
`define SAF_STATUS_OFFSET 8'h04
`define SAF_MASK_OFFSET 8'h08
`define SAF_LAST_OFFSET 8'h0C
`define SAF_COUNT_OFFSET 8'h10
`define SAF_SIZES_OFFSET 8'h14

// control bits
`define SAF_CTRL_ENABLE_BIT 0
`define SAF_CTRL_RESET 32'h0000_0001

// status and mask bit positions
`define SAF_ST_GP_BIT 0
`define SAF_ST_AC_BIT 1
`define SAF_ST_WIDTH 2

// encoding class
`define SAF_ENC_LEGACY 1'b0
`define SAF_ENC_PREFIXED 1'b1

// access category
`define SAF_CAT_ALIGNED 2'h0
`define SAF_CAT_UNALIGNED 2'h1
`define SAF_CAT_ARITH 2'h2

// size codes, log2 of the byte count
`define SAF_SZ_1 3'h0
`define SAF_SZ_2 3'h1
`define SAF_SZ_4 3'h2
`define SAF_SZ_8 3'h3
`define SAF_SZ_16 3'h4
`define SAF_SZ_32 3'h5

// fault result codes
`define SAF_RES_NONE 2'h0
`define SAF_RES_GP 2'h1
`define SAF_RES_AC 2'h2

// user privilege level
`define SAF_CPL_USER 2'h3

// bus answers a read one cycle after it is issued
`define SAF_RD_LATENCY 1

`endif

/* File: logic/saf_count_mem.v */
// small register file holding per-size fault counters
`timescale 1ns/10ps
module saf_count_mem #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter DW = 16
) (
  input wire core_clk,
  input wire rst,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {DW{1'b0}};
      rd_data <= {DW{1'b0}};
    end
    else
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule // saf_count_mem

/* File: logic/saf_check.v */
// alignment fault classifier for vector loads and stores, avalon slave
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "saf_defines.vh"
module saf_check #(
  parameter AW = 64,
  parameter CW = 16
) (
  input wire core_clk,
  input wire rst,
  input wire req_valid,
  input wire [AW-1:0] req_addr,
  input wire req_enc,
  input wire [1:0] req_cat,
  input wire [2:0] req_size,
  input wire alignment_check_flag,
  input wire alignment_mask_control_bit,
  input wire [1:0] cpl,
  output reg resp_valid,
  output reg [1:0] resp_fault,
  output reg general_protection_fault,
  output reg alignment_check_fault,
  output reg commit_ok,
  output reg split_access,
  output reg irq,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);
  reg [31:0] ctrl_reg;
  reg [`SAF_ST_WIDTH-1:0] status_reg;
  reg [`SAF_ST_WIDTH-1:0] mask_reg;
  reg [31:0] last_reg;
  reg [31:0] count_reg;
  reg rd_pend_reg;
  reg [1:0] fault_next;
  reg ac_enable;
  reg misaligned;
  wire [CW-1:0] mem_rd;
  wire [CW-1:0] mem_wr;
  reg mem_sel_reg;

  // true if any address bit below the alignment is set
  function mis_check;
    input [5:0] low;
    input [2:0] sz;
    reg [5:0] m;
    begin
      m = (6'h01 << sz) - 6'h01;
      mis_check = |(low & m);
    end
  endfunction

  // byte-enable merge for a 32-bit register write
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          be_merge[k*8 +: 8] = wd[k*8 +: 8];
    end
  endfunction

  always @*
  begin
    misaligned = mis_check(req_addr[5:0], req_size);
    ac_enable = alignment_check_flag && (cpl == `SAF_CPL_USER) &&
      alignment_mask_control_bit;
    fault_next = `SAF_RES_NONE;
    if (misaligned && ctrl_reg[`SAF_CTRL_ENABLE_BIT])
    begin
      if (req_enc == `SAF_ENC_LEGACY)
      begin
        if (req_size >= `SAF_SZ_16)
        begin
          if (req_cat == `SAF_CAT_ALIGNED)
            fault_next = `SAF_RES_GP;
          else if (req_cat == `SAF_CAT_ARITH)
            fault_next = `SAF_RES_GP;
          else
            fault_next = `SAF_RES_NONE;
        end
        else if (ac_enable && req_size != `SAF_SZ_1)
          fault_next = `SAF_RES_AC;
      end
      else
      begin
        if (req_size >= `SAF_SZ_16)
        begin
          if (req_cat == `SAF_CAT_ALIGNED)
            fault_next = `SAF_RES_GP;
          else
            fault_next = `SAF_RES_NONE;
        end
        else if (ac_enable && req_size != `SAF_SZ_1)
          fault_next = `SAF_RES_AC;
      end
    end
  end

  // per-size counter memory, each fault writes its size entry with the word read the cycle before plus one
  assign mem_wr = mem_rd + {{(CW-1){1'b0}}, 1'b1};

  saf_count_mem #(
    .DEPTH(8),
    .AW(3),
    .DW(CW)
  ) u_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(mem_sel_reg),
    .wr_addr(last_reg[2:0]),
    .wr_data(mem_wr),
    .rd_addr(mem_sel_reg ? last_reg[2:0] : avs_writedata[2:0]),
    .rd_data(mem_rd)
  );

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      resp_valid <= 1'b0;
      resp_fault <= `SAF_RES_NONE;
      general_protection_fault <= 1'b0;
      alignment_check_fault <= 1'b0;
      commit_ok <= 1'b0;
      split_access <= 1'b0;
      mem_sel_reg <= 1'b0;
    end
    else
    begin
      resp_valid <= req_valid;
      resp_fault <= req_valid ? fault_next : `SAF_RES_NONE;
      general_protection_fault <= req_valid && fault_next == `SAF_RES_GP;
      alignment_check_fault <= req_valid && fault_next == `SAF_RES_AC;
      commit_ok <= req_valid && fault_next == `SAF_RES_NONE;
      // misaligned access of any size that raised no fault flagged as non-atomic
      split_access <= req_valid && misaligned &&
        fault_next == `SAF_RES_NONE;
      mem_sel_reg <= req_valid && fault_next != `SAF_RES_NONE;
    end
  end

  // registers and interrupt
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `SAF_CTRL_RESET;
      status_reg <= {`SAF_ST_WIDTH{1'b0}};
      mask_reg <= {`SAF_ST_WIDTH{1'b0}};
      last_reg <= 32'h0000_0000;
      count_reg <= 32'h0000_0000;
      rd_pend_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      // set wins over write-one-to-clear
      if (avs_write && !avs_waitrequest &&
        avs_address == `SAF_STATUS_OFFSET && avs_byteenable[0])
        status_reg <= (status_reg & ~avs_writedata[1:0]) |
          {resp_fault == `SAF_RES_AC && resp_valid,
           resp_fault == `SAF_RES_GP && resp_valid};
      else
        status_reg <= status_reg |
          {resp_fault == `SAF_RES_AC && resp_valid,
           resp_fault == `SAF_RES_GP && resp_valid};
      if (resp_valid && resp_fault != `SAF_RES_NONE)
        count_reg <= count_reg + 32'h0000_0001;
      if (req_valid && fault_next != `SAF_RES_NONE)
        last_reg <= {21'h00_0000, fault_next, req_enc, req_cat,
          req_addr[2:0], req_size};
      irq <= |(status_reg & mask_reg);
      avs_waitrequest <= 1'b1;
      rd_pend_reg <= 1'b0;
      // a write lands only at the edge the master sees waitrequest low
      if (avs_write && !avs_waitrequest)
      begin
        if (avs_address == `SAF_CTRL_OFFSET)
          ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable);
        else if (avs_address == `SAF_MASK_OFFSET && avs_byteenable[0])
          mask_reg <= avs_writedata[1:0];
      end
      if (avs_write && avs_waitrequest)
        avs_waitrequest <= 1'b0;
      else if (avs_read && avs_waitrequest && !rd_pend_reg)
      begin
        rd_pend_reg <= 1'b1;
        avs_waitrequest <= 1'b0;
        if (avs_address == `SAF_CTRL_OFFSET)
          avs_readdata <= ctrl_reg;
        else if (avs_address == `SAF_STATUS_OFFSET)
          avs_readdata <= {30'h0000_0000, status_reg};
        else if (avs_address == `SAF_MASK_OFFSET)
          avs_readdata <= {30'h0000_0000, mask_reg};
        else if (avs_address == `SAF_LAST_OFFSET)
          avs_readdata <= last_reg;
        else if (avs_address == `SAF_COUNT_OFFSET)
          avs_readdata <= count_reg;
        else
          avs_readdata <= 32'h0000_0000;
      end
    end
  end
endmodule // saf_check

/* File: tb/saf_check_checker.sv */
// port assertions for the alignment fault checker
`timescale 1ns/10ps
`include "saf_defines.vh"
module saf_check_chk #(
  parameter AW = 64,
  parameter CW = 16
) (
  input wire core_clk,
  input wire rst,
  input wire req_valid,
  input wire req_enc,
  input wire [1:0] req_cat,
  input wire [2:0] req_size,
  input wire alignment_check_flag,
  input wire alignment_mask_control_bit,
  input wire [1:0] cpl,
  input wire resp_valid,
  input wire [1:0] resp_fault,
  input wire general_protection_fault,
  input wire alignment_check_fault,
  input wire commit_ok,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire ac_en = alignment_check_flag & alignment_mask_control_bit
    & (cpl == `SAF_CPL_USER);
  AST_RESP_LAT:
    assert property (req_valid |=> resp_valid) else $error("no answer");
  AST_NO_SPUR:
    assert property (!req_valid |=> !resp_valid) else $error("stray answer");
  AST_AC_EN:
    assert property (req_valid && !ac_en |=> !alignment_check_fault)
    else $error("ac while disabled");
  AST_AC_WIDE:
    assert property (req_valid && req_enc && req_size >= `SAF_SZ_16
      |=> !alignment_check_fault) else $error("ac on wide ref");
  AST_GP_UNAL:
    assert property (req_valid && !req_enc && req_cat == `SAF_CAT_UNALIGNED
      |=> !general_protection_fault) else $error("gp on unaligned move");
  AST_GP_PARITH:
    assert property (req_valid && req_enc && req_cat == `SAF_CAT_ARITH
      |=> !general_protection_fault) else $error("gp on prefixed arith");
  AST_BYTE:
    assert property (req_valid && req_size == `SAF_SZ_1
      |=> resp_fault == `SAF_RES_NONE) else $error("byte faulted");
  AST_CODE:
    assert property (resp_valid |-> resp_fault ==
      {alignment_check_fault, general_protection_fault}
      && commit_ok == (resp_fault == `SAF_RES_NONE)) else $error("bad code");
  AST_BUS:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus late");
  cover property (general_protection_fault);
  cover property (alignment_check_fault);
  cover property (resp_valid && commit_ok);
endmodule // saf_check_chk
bind saf_check saf_check_chk #(.AW(AW), .CW(CW)) u_chk (.*);

/* File: tb/saf_decode_model.sv */
// load/store pipeline model that issues accesses
`timescale 1ns/10ps
module saf_decode_model (
  input wire core_clk,
  output reg req_valid = 0,
  output reg [63:0] req_addr = 0,
  output reg req_enc = 0,
  output reg [1:0] req_cat = 0,
  output reg [2:0] req_size = 0,
  output reg alignment_check_flag = 0,
  output reg alignment_mask_control_bit = 0,
  output reg [1:0] cpl = 0
);
  task issue(input [63:0] a, input e, input [1:0] c, input [2:0] s,
    input f, input m, input [1:0] p);
  begin
    req_valid <= 1;
    req_addr <= a;
    req_enc <= e;
    req_cat <= c;
    req_size <= s;
    alignment_check_flag <= f;
    alignment_mask_control_bit <= m;
    cpl <= p;
    @(posedge core_clk);
  end
  endtask
  // address goes stale when idle, so no leftover value is trusted
  task idle;
  begin
    req_valid <= 0;
    req_addr <= ~req_addr;
    @(posedge core_clk);
  end
  endtask
endmodule // saf_decode_model

/* File: tb/saf_tb.sv */
// self-checking bench for the alignment fault checker
`timescale 1ns/10ps
`include "saf_defines.vh"
module testbench;
  reg core_clk = 0;
  reg rst = 1;
  reg [7:0] avs_address = 0;
  reg avs_read = 0;
  reg avs_write = 0;
  reg [31:0] avs_writedata = 0;
  wire [3:0] avs_byteenable = 4'hf;
  wire req_valid, req_enc, alignment_check_flag, alignment_mask_control_bit;
  wire [63:0] req_addr;
  wire [1:0] req_cat, cpl, resp_fault;
  wire [2:0] req_size;
  wire resp_valid, general_protection_fault, alignment_check_fault;
  wire commit_ok, split_access, irq, avs_waitrequest;
  wire [31:0] avs_readdata;
  integer num_errors = 0;
  integer total_checks = 0;
  integer i;
  reg [2:0] exp_q[$];
  reg [2:0] got;
  integer nf = 0;
  reg [31:0] rd;
  reg [1:0] st_exp = 0;
  reg en = 1;
  reg e;
  reg [2:0] s;
  always #5 core_clk = ~core_clk;
  saf_decode_model dec (.*);
  saf_check dut (.*);
  task cmp_fault(input [1:0] x, input [1:0] g);
  begin
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("wrong value resp_fault exp %h got %h", x, g);
    end
  end
  endtask
  task cmp_word(input string n, input [31:0] x, input [31:0] g);
  begin
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  end
  endtask
  task report_and_stop;
  begin
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task bus(input w, input [7:0] ad, input [31:0] d);
    integer k;
  begin
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    k = 0;
    @(negedge core_clk);
    while (avs_waitrequest !== 1'b0 && k < 50)
    begin
      k++;
      @(negedge core_clk);
    end
    if (k == 50)
      num_errors++;
    // read data stands until the edge that ends the request
    rd = avs_readdata;
    @(posedge core_clk);
    avs_read <= 0;
    avs_write <= 0;
    @(posedge core_clk);
  end
  endtask
  // misaligned when any address bit below the access size is set
  task send(input [63:0] a, input e, input [1:0] c, input [2:0] s,
    input f, input m, input [1:0] p);
    reg [1:0] x;
    reg mis;
  begin
    x = `SAF_RES_NONE;
    mis = (a[5:0] & ((6'h01 << s) - 6'h01)) != 0;
    if (en && s != `SAF_SZ_1 && mis)
      if (s >= `SAF_SZ_16)
        x = (c == `SAF_CAT_ALIGNED || (!e && c == `SAF_CAT_ARITH))
          ? `SAF_RES_GP : `SAF_RES_NONE;
      else if (f && m && p == `SAF_CPL_USER)
        x = `SAF_RES_AC;
    exp_q.push_back({mis && x == `SAF_RES_NONE, x});
    if (x != `SAF_RES_NONE) nf = nf + 1;
    if (x == `SAF_RES_GP) st_exp[`SAF_ST_GP_BIT] = 1;
    if (x == `SAF_RES_AC) st_exp[`SAF_ST_AC_BIT] = 1;
    dec.issue(a, e, c, s, f, m, p);
  end
  endtask
  always @(posedge core_clk)
    if (resp_valid === 1'b1)
    begin
      got = exp_q.size() ? exp_q.pop_front() : 3'h7;
      cmp_fault(got[1:0], resp_fault);
      cmp_word("split_access", got[2], split_access);
    end
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  initial
  begin
    i = $urandom(94);
    repeat (8) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    bus(0, `SAF_CTRL_OFFSET, 0);
    cmp_word("ctrl", `SAF_CTRL_RESET, rd);
    bus(1, 8'hfc, 32'hffff_ffff);
    bus(0, 8'hfc, 0);
    cmp_word("unmapped", 0, rd);
    repeat (2)
    begin
      for (i = 0; i < 300; i++)
      begin
        e = $urandom;
        s = $urandom % (e ? 6 : 5);
        send($urandom, e, $urandom % 3, s, $urandom, $urandom,
          ($urandom % 4) ? 2'h3 : 2'h0);
      end
      dec.idle;
      repeat (3) @(posedge core_clk);
      bus(0, `SAF_STATUS_OFFSET, 0);
      cmp_word("status", st_exp, rd);
      bus(0, `SAF_COUNT_OFFSET, 0);
      cmp_word("count", nf, rd);
      cmp_word("irq masked", 0, irq);
      bus(1, `SAF_MASK_OFFSET, 3);
      repeat (2) @(posedge core_clk);
      cmp_word("irq", |st_exp, irq);
      bus(1, `SAF_STATUS_OFFSET, 3);
      bus(1, `SAF_MASK_OFFSET, 0);
      st_exp = 0;
      bus(0, `SAF_STATUS_OFFSET, 0);
      cmp_word("cleared", 0, rd);
      cmp_word("irq low", 0, irq);
      bus(1, `SAF_CTRL_OFFSET, 0);
      en = 0;
    end
    report_and_stop;
  end
endmodule // testbench
